/* File: inc/word_increment_pkg.sv */
// Package for the word increment unit: bus map, flag layout, opcodes and carriers.
// Assumes one core clock and a synchronous active-high core reset.
package word_increment_pkg;

  // Register bus widths.
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // Register file holds the general registers; control registers sit above it.
  localparam logic [8:0] OFF_DST    = 9'h100;
  localparam logic [8:0] OFF_OPC    = 9'h101;
  localparam logic [8:0] OFF_FLAGS  = 9'h102;
  localparam logic [8:0] OFF_STATUS = 9'h103;
  localparam logic [8:0] OFF_WBASE  = 9'h104;

  // Status bit positions.
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_BADOP_BIT = 1;

  // Values after reset.
  localparam logic [7:0] DST_RST   = 8'h00;
  localparam logic [7:0] OPC_RST   = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] WBASE_RST = 8'h00;

  // Instruction codes and the operand prefix that selects a working register.
  localparam logic [7:0] OPC_TWO_CELL = 8'ha0;
  localparam logic [7:0] OPC_PTD_CELL = 8'ha1;
  localparam logic [3:0] WREG_PREFIX  = 4'he;

  // Cycles taken by one word increment, from command to done.
  localparam int OP_CYCLES = 8;

  // Flag register layout, most significant bit first.
  typedef struct packed {
    logic       unsigned_wrap_flag;
    logic       null_out_flag;
    logic       top_bit_flag;
    logic       wrap_flag;
    logic       nibble_arith_type_bit;
    logic       nibble_carry;
    logic [1:0] spare;
  } flags_t;

  // One register bus request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

endpackage : word_increment_pkg

/* File: core/pair_ram.sv */
// Dual-port byte memory holding the general register file.
// Port A serves software and can return a bypass value; port B serves the
// instruction sequencer. Both read data come out of registers.
module pair_ram #(
  parameter int DEPTH = 256
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_a_addr,
  input  wire logic       i_a_wr,
  input  wire logic [7:0] i_a_wdata,
  input  wire logic       i_a_rd,
  input  wire logic [7:0] i_a_byp,
  output logic      [7:0] o_a_q,
  input  wire logic [7:0] i_b_addr,
  input  wire logic       i_b_wr,
  input  wire logic [7:0] i_b_wdata,
  output logic      [7:0] o_b_q
);

  logic [7:0] mem [DEPTH];
  logic [7:0] a_q_next;

  // Port A returns the array on a read and the bypass value otherwise.
  always_comb begin
    a_q_next = i_a_rd ? mem[i_a_addr] : i_a_byp;
  end

  // Writes and registered reads; the caller never writes both ports at once.
  always_ff @(posedge i_clk_sys) begin
    if (i_a_wr) begin
      mem[i_a_addr] <= i_a_wdata;
    end
    if (i_b_wr) begin
      mem[i_b_addr] <= i_b_wdata;
    end
    if (i_rst) begin
      o_a_q <= 8'h00;
      o_b_q <= 8'h00;
    end else begin
      o_a_q <= a_q_next;
      o_b_q <= mem[i_b_addr];
    end
  end

endmodule : pair_ram

/* File: core/word_increment_unit.sv */
// Word increment execution unit with its general register file.
// Assumes a bus master that issues one-cycle strobes and takes read data
// in the following cycle, and software that loads operands before a command.
// The general register file is not cleared by reset.
//
// Operation
// - Treat the even byte and next byte as one word, store word plus one.
// - Zero flag follows the whole word; carry, decimal and half flags stay.
// - Sign flag copies the top bit of the incremented word.
// - Overflow flag set only on signed overflow of the word.
// - Direct mode increments the named register pair, low byte in odd register.
// - Indirect mode takes pair address from a register; low wrap carries high.
module word_increment_unit #(
  parameter int RAM_DEPTH = 256
) (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst,
  input  word_increment_pkg::bus_req_t       i_bus,
  output logic [word_increment_pkg::DATA_W-1:0] o_rdata,
  output logic                               o_busy,
  output logic                               o_done,
  output word_increment_pkg::flags_t         o_flags
);
  import word_increment_pkg::*;

  typedef enum {S_IDLE, S_PTR, S_HI, S_LO, S_ADD, S_WLO, S_WHI, S_FIN} state_t;

  // Sequencer and control registers, each beside its next value.
  state_t     state_reg,  state_next;
  logic [7:0] dst_reg,    dst_next;
  logic [7:0] opc_reg,    opc_next;
  logic [7:0] wbase_reg,  wbase_next;
  logic [7:0] ptr_reg,    ptr_next;
  logic [7:0] hi_reg,     hi_next;
  logic [7:0] lo_reg,     lo_next;
  logic [15:0] sum_reg,   sum_next;
  logic       ind_reg,    ind_next;
  logic       badop_reg,  badop_next;
  logic       busy_next;
  logic       done_next;
  flags_t     flags_next;

  // Bus decode and memory port signals.
  logic       wr_ok;
  logic       start_try;
  logic       start;
  logic       a_rd;
  logic       a_wr;
  logic [7:0] a_byp;
  logic [7:0] b_addr;
  logic       b_wr;
  logic [7:0] b_wdata;
  logic [7:0] b_q;

  // Resolves an operand byte to a register address, mapping working registers.
  // Working registers live in the sixteen-byte bank chosen by the base register.
  function automatic logic [7:0] pick_reg(input logic [7:0] base, input logic [7:0] sel);
    pick_reg = (sel[7:4] == WREG_PREFIX) ? {base[7:4], sel[3:0]} : sel;
  endfunction : pick_reg

  // Writes are refused while an instruction runs, so the pair stays atomic.
  // A bad opcode never starts the sequencer; it is still loaded into the opcode register and raises the sticky status bit.
  // Opcodes a0 and a1 differ only in the addressing mode that they select.
  always_comb begin
    wr_ok     = i_bus.wr && (state_reg == S_IDLE);
    start_try = wr_ok && (i_bus.addr == OFF_OPC);
    start     = start_try && ((i_bus.wdata == OPC_TWO_CELL) || (i_bus.wdata == OPC_PTD_CELL));
    a_wr      = wr_ok && !i_bus.addr[8];
    a_rd      = i_bus.rd && !i_bus.addr[8];
  end

  // Control register reads go through the memory bypass to leave a flop.
  // Using the memory's output register keeps the read data a flop output and
  // gives control and general registers the same one-cycle read latency.
  always_comb begin
    a_byp = 8'h00;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        OFF_DST:    a_byp = dst_reg;
        OFF_OPC:    a_byp = opc_reg;
        OFF_FLAGS:  a_byp = o_flags;
        OFF_STATUS: begin
          a_byp[ST_BUSY_BIT]  = o_busy;
          a_byp[ST_BADOP_BIT] = badop_reg;
        end
        OFF_WBASE:  a_byp = wbase_reg;
        default:    a_byp = 8'h00;
      endcase
    end
  end

  // Software side of the control registers; a rejected opcode sets a sticky bit.
  // The status bit is write-one-to-clear; a set and a clear cannot meet in one
  // cycle because they need different addresses.
  always_comb begin
    dst_next   = dst_reg;
    opc_next   = opc_reg;
    wbase_next = wbase_reg;
    badop_next = badop_reg;
    if (wr_ok && (i_bus.addr == OFF_DST)) begin
      dst_next = i_bus.wdata;
    end
    if (wr_ok && (i_bus.addr == OFF_WBASE)) begin
      wbase_next = i_bus.wdata;
    end
    if (start_try) begin
      opc_next = i_bus.wdata;
    end
    if (wr_ok && (i_bus.addr == OFF_STATUS) && i_bus.wdata[ST_BADOP_BIT]) begin
      badop_next = 1'b0;
    end
    if (start_try && !start) begin
      badop_next = 1'b1;
    end
  end

  // Instruction sequencer: fetch pointer, read pair, add, write pair back.
  // Port B data lag one cycle behind the address, so each state uses what the
  // previous state addressed. The low byte is written first and the high byte
  // last, so a read after done always sees the whole new word.
  // Flags land three cycles before done; software flag writes are dropped unless idle.
  always_comb begin
    state_next = state_reg;
    ptr_next   = ptr_reg;
    hi_next    = hi_reg;
    lo_next    = lo_reg;
    sum_next   = sum_reg;
    ind_next   = ind_reg;
    flags_next = o_flags;
    b_addr     = 8'h00;
    b_wr       = 1'b0;
    b_wdata    = 8'h00;
    if (wr_ok && (i_bus.addr == OFF_FLAGS)) begin
      flags_next = i_bus.wdata;
    end
    unique case (state_reg)
      S_IDLE: begin
        if (start) begin
          ind_next   = (i_bus.wdata == OPC_PTD_CELL);
          state_next = S_PTR;
        end
      end
      S_PTR: begin
        b_addr     = pick_reg(wbase_reg, dst_reg);
        state_next = S_HI;
      end
      S_HI: begin
        ptr_next   = ind_reg ? b_q : pick_reg(wbase_reg, dst_reg);
        b_addr     = {ptr_next[7:1], 1'b0};
        state_next = S_LO;
      end
      S_LO: begin
        b_addr     = {ptr_reg[7:1], 1'b1};
        hi_next    = b_q;
        state_next = S_ADD;
      end
      S_ADD: begin
        lo_next  = b_q;
        sum_next = {hi_reg, b_q} + 16'h0001;
        flags_next.null_out_flag = (sum_next == 16'h0000);
        flags_next.top_bit_flag  = sum_next[15];
        flags_next.wrap_flag     = (sum_next == 16'h8000);
        state_next = S_WLO;
      end
      S_WLO: begin
        b_wr       = 1'b1;
        b_addr     = {ptr_reg[7:1], 1'b1};
        b_wdata    = sum_reg[7:0];
        state_next = S_WHI;
      end
      S_WHI: begin
        b_wr       = 1'b1;
        b_addr     = {ptr_reg[7:1], 1'b0};
        b_wdata    = sum_reg[15:8];
        state_next = S_FIN;
      end
      S_FIN: begin
        state_next = S_IDLE;
      end
    endcase
    busy_next = (state_next != S_IDLE);
    done_next = (state_reg == S_FIN);
  end

  // Registers of the unit.
  // Every output port of the unit but o_rdata is one of these flops; o_rdata is the memory's port A register.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg <= S_IDLE;
      dst_reg   <= DST_RST;
      opc_reg   <= OPC_RST;
      wbase_reg <= WBASE_RST;
      ptr_reg   <= 8'h00;
      hi_reg    <= 8'h00;
      lo_reg    <= 8'h00;
      sum_reg   <= 16'h0000;
      ind_reg   <= 1'b0;
      badop_reg <= 1'b0;
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
      o_flags   <= FLAGS_RST;
    end else begin
      state_reg <= state_next;
      dst_reg   <= dst_next;
      opc_reg   <= opc_next;
      wbase_reg <= wbase_next;
      ptr_reg   <= ptr_next;
      hi_reg    <= hi_next;
      lo_reg    <= lo_next;
      sum_reg   <= sum_next;
      ind_reg   <= ind_next;
      badop_reg <= badop_next;
      o_busy    <= busy_next;
      o_done    <= done_next;
      o_flags   <= flags_next;
    end
  end

  // General register file; port A output is the bus read data.
  // Port A writes only when idle and port B only when busy, so they never collide.
  pair_ram #(
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_a_addr  (i_bus.addr[7:0]),
    .i_a_wr    (a_wr),
    .i_a_wdata (i_bus.wdata),
    .i_a_rd    (a_rd),
    .i_a_byp   (a_byp),
    .o_a_q     (o_rdata),
    .i_b_addr  (b_addr),
    .i_b_wr    (b_wr),
    .i_b_wdata (b_wdata),
    .o_b_q     (b_q)
  );

  // Checks on the sequencer and flag results.
  // They look at internal state so that a failure points at the stage at fault.
  // The covers show both modes, the flag corner cases and a refused opcode.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  word_sum_a: assert property (
    (state_reg == S_WHI) |-> ({b_wdata, $past(b_wdata)} == ({hi_reg, lo_reg} + 16'h0001)))
    else $error("Written word is not the read word plus one.");

  null_flag_a: assert property (
    (state_reg == S_WLO) |-> (o_flags.null_out_flag == ({hi_reg, lo_reg} == 16'hffff)))
    else $error("Zero flag does not follow the word result.");

  keep_flags_a: assert property (
    o_busy |=> ($stable(o_flags.unsigned_wrap_flag) && $stable(o_flags.nibble_arith_type_bit)
                && $stable(o_flags.nibble_carry)))
    else $error("Untouched flag changed during a word increment.");

  top_bit_a: assert property (
    $rose(o_done) |-> (o_flags.top_bit_flag == sum_reg[15]))
    else $error("Sign flag does not match the result top bit.");

  wrap_flag_a: assert property (
    (state_reg == S_WLO) |-> (o_flags.wrap_flag == ({hi_reg, lo_reg} == 16'h7fff)))
    else $error("Overflow flag wrong for the word increment.");

  op_length_a: assert property (
    start |=> (o_busy && !o_done) [*7] ##1 (o_done && !o_busy))
    else $error("Word increment did not finish in eight cycles.");

  direct_pair_a: assert property (
    (state_reg == S_LO && !ind_reg) |-> (ptr_reg == pick_reg(wbase_reg, dst_reg)) && (b_addr[0] == 1'b1))
    else $error("Direct mode used the wrong register pair.");

  ptd_carry_a: assert property (
    (state_reg == S_LO && ind_reg) |-> (ptr_reg == $past(b_q)) ##3
    (b_wdata == (hi_reg + ((lo_reg == 8'hff) ? 8'h01 : 8'h00))))
    else $error("Indirect mode pointer or high byte carry wrong.");

  done_pulse_a: assert property (
    o_done |-> !o_busy ##1 !o_done)
    else $error("Done is not a single idle-cycle pulse.");

  pair_write_a: assert property (
    (state_reg == S_WLO) |-> (b_wr && (b_addr == {ptr_reg[7:1], 1'b1})) ##1
    (b_wr && (b_addr == {ptr_reg[7:1], 1'b0})))
    else $error("Pair write-back missed the odd or even byte.");

  busy_refuse_a: assert property (
    (o_busy && i_bus.wr) |=> ($stable(dst_reg) && $stable(wbase_reg) && $stable(opc_reg)))
    else $error("Control register changed by a write during an instruction.");

  mode_latch_a: assert property (
    start |=> (ind_reg == ($past(i_bus.wdata) == OPC_PTD_CELL)))
    else $error("Addressing mode not taken from the opcode.");

  direct_done_c: cover property (start && i_bus.wdata == OPC_TWO_CELL ##8 o_done);
  ptd_done_c: cover property (start && i_bus.wdata == OPC_PTD_CELL ##8 o_done);
  overflow_c: cover property ($rose(o_done) && o_flags.wrap_flag);
  zero_c: cover property ($rose(o_done) && o_flags.null_out_flag);
  refused_c: cover property (start_try && !start);

endmodule : word_increment_unit

/* File: testbench/word_increment_unit_tb.sv */
// Self-checking bench for the word increment unit: reset values, both modes, flags, refusals.
// Assumes the design package, one 40 MHz clock and a synchronous active-high reset.
module word_increment_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import word_increment_pkg::*;

  logic       i_clk_sys;
  logic       i_rst;
  bus_req_t   i_bus;
  logic [7:0] o_rdata;
  logic       o_busy;
  logic       o_done;
  flags_t     o_flags;
  logic [7:0] rq[$];
  logic [7:0] fq[$];
  int         failures;
  int         n_compared;
  int         since;
  int         busy_n;
  logic       rd_seen;

  word_increment_unit u_word_increment_unit (
    .i_clk_sys(i_clk_sys),
    .i_rst    (i_rst),
    .i_bus    (i_bus),
    .o_rdata  (o_rdata),
    .o_busy   (o_busy),
    .o_done   (o_done),
    .o_flags  (o_flags)
  );

  // Free-running core clock, 25 ns period.
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic check(input logic ok, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (!ok) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic cmp_rdata(input logic [7:0] got, input logic [7:0] exp);
    check(got === exp, {8'h00, got}, {8'h00, exp});
  endtask : cmp_rdata

  task automatic cmp_flags(input logic [7:0] got, input logic [7:0] exp);
    check(got === exp, {8'h00, got}, {8'h00, exp});
  endtask : cmp_flags

  task automatic cmp_cycles(input int got, input int exp);
    check(got == exp, 16'(got), 16'(exp));
  endtask : cmp_cycles

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk_sys);
    i_bus.wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the expected byte is noted for the monitor.
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge i_clk_sys);
    i_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk_sys);
    i_bus.rd <= 1'b0;
  endtask : rd

  // Loads a pair, runs one word increment, then reads the stored word back.
  task automatic run_op(input logic [7:0] opc, input logic [7:0] dst, input logic [7:0] pair,
                        input logic [15:0] w, input logic [7:0] fin, input bit poke);
    logic [15:0] r;
    int          k;
    r = w + 16'h0001;
    k = 0;
    wr({1'b0, pair}, w[15:8]);
    wr({1'b0, pair | 8'h01}, w[7:0]);
    wr(OFF_FLAGS, fin);
    wr(OFF_DST, dst);
    fq.push_back((fin & 8'h8f) | {1'b0, r == 16'h0000, r[15], r == 16'h8000, 4'h0});
    wr(OFF_OPC, opc);
    if (poke) wr(OFF_FLAGS, 8'h00); // Dropped while busy, so carry, decimal and half stay.
    rd(OFF_STATUS, 8'h01);
    while (!o_done && k < 12) begin
      @(negedge i_clk_sys);
      k++;
    end
    rd({1'b0, pair}, r[15:8]);
    rd({1'b0, pair | 8'h01}, r[7:0]);
  endtask : run_op

  // Monitor: read data the cycle after a strobe, flags and latency at each done pulse.
  always @(posedge i_clk_sys) begin
    if (rd_seen) cmp_rdata(o_rdata, rq.pop_front());
    rd_seen <= i_bus.rd & ~i_rst;
    since <= since + 1;
    if (i_bus.wr && i_bus.addr == OFF_OPC && (i_bus.wdata == OPC_TWO_CELL || i_bus.wdata == OPC_PTD_CELL))
      since <= 1;
    busy_n <= o_busy ? busy_n + 1 : 0;
    if (o_done) begin
      cmp_cycles(since, OP_CYCLES);
      cmp_cycles(busy_n, OP_CYCLES - 1);
      cmp_flags(o_flags, fq.pop_front());
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (6000) @(posedge i_clk_sys);
    failures++;
    tally_and_finish();
  end

  initial begin
    logic [15:0] w;
    logic [7:0]  p;
    logic [7:0]  fin;
    i_rst = 1'b1;
    i_bus = '0;
    rd_seen = 1'b0;
    since = 0;
    busy_n = 0;
    failures = 0;
    n_compared = 0;
    void'($urandom(31741));
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(OFF_DST, DST_RST);
    rd(OFF_OPC, OPC_RST);
    rd(OFF_FLAGS, FLAGS_RST);
    rd(OFF_WBASE, WBASE_RST);
    rd(OFF_STATUS, 8'h00);
    rd(9'h1ff, 8'h00);
    $display("test reset values done");
    wr(OFF_WBASE, 8'h30);
    run_op(OPC_TWO_CELL, 8'he0, 8'h30, 16'h1a02, 8'h70, 1'b0);
    run_op(OPC_TWO_CELL, 8'h42, 8'h42, 16'h0fff, 8'h8c, 1'b1);
    run_op(OPC_TWO_CELL, 8'he2, 8'h32, 16'hffff, 8'h84, 1'b0);
    run_op(OPC_TWO_CELL, 8'h50, 8'h50, 16'h7fff, 8'h08, 1'b0);
    run_op(OPC_TWO_CELL, 8'h52, 8'h52, 16'h8000, 8'h10, 1'b0);
    wr(9'h035, 8'h02);
    run_op(OPC_PTD_CELL, 8'he5, 8'h02, 16'h0fff, 8'h70, 1'b0);
    $display("test directed cases done");
    // Random words, alternating modes, always on even pairs.
    for (int i = 0; i < 40; i++) begin
      w = 16'($urandom());
      p = {2'b10, 5'($urandom()), 1'b0};
      fin = 8'($urandom()) & 8'hfc;
      if (i[0]) begin
        wr(9'h020, p);
        run_op(OPC_PTD_CELL, 8'h20, p, w, fin, 1'b0);
      end else begin
        run_op(OPC_TWO_CELL, p, p, w, fin, 1'b0);
      end
    end
    $display("test random cases done");
    // Unknown opcodes run nothing and leave a sticky status bit.
    for (int j = 0; j < 2; j++) begin
      wr(OFF_OPC, (j != 0) ? 8'ha2 : 8'h55);
      rd(OFF_OPC, (j != 0) ? 8'ha2 : 8'h55);
      rd(OFF_STATUS, 8'h02);
      wr(OFF_STATUS, 8'h02);
      rd(OFF_STATUS, 8'h00);
    end
    $display("test bad opcode done");
    repeat (4) @(posedge i_clk_sys);
    if (fq.size() != 0 || rq.size() != 0) failures++;
    tally_and_finish();
  end
endmodule : word_increment_unit_tb
